// ==== pkg/rlv_regs.vh ====
`ifndef RLV_REGS_VH
`define RLV_REGS_VH
// register word offsets
`define RLV_A_CTRL   4'h0
`define RLV_A_STAT   4'h1
`define RLV_A_HW1    4'h2
`define RLV_A_HW2    4'h3
`define RLV_A_HW3    4'h4
`define RLV_A_HW4    4'h5
`define RLV_A_SUM    4'h6
`define RLV_A_CNT    4'h7
// control bits
`define RLV_C_GO     0
`define RLV_C_VFY    1
// status bits
`define RLV_S_ACT    0
`define RLV_S_DONE   1
`define RLV_S_ECSUM  2
`define RLV_S_ECNT   3
`define RLV_S_EHDR   4
`define RLV_S_EBUS   5
`define RLV_S_JUMP   6
// subaddresses and word counts (0 means 32)
`define RLV_SA_HDR   5'h14
`define RLV_SA_DATA  5'h15
`define RLV_SA_TRL   5'h16
`define RLV_WC_HDR   5'h04
`define RLV_WC_TRL   5'h02
`define RLV_WC_FULL  5'h00
// header fields
`define RLV_TM_HI    15
`define RLV_TM_LO    14
`define RLV_HT_HI    13
`define RLV_HT_LO    12
`define RLV_BTC_HI   11
`define RLV_PG_LO    3
`define RLV_TC_HI    1
`define RLV_TM_NONE  2'h0
`define RLV_TM_8     2'h1
`define RLV_TM_32    2'h3
`define RLV_HT_WORDS 2'h0
`define RLV_HT_MSGS  2'h1
`define RLV_TC_JUMP  2'h2
`define RLV_TC_BAD   2'h3
// counts
`define RLV_BTC_MAX  13'h1000
`define RLV_PG_MAX   13'h0800
`define RLV_MSG_SH   5
`define RLV_MSG_M1   13'h001f
`define RLV_LO8      16'h00ff
`endif

// ==== verif/rlv_ldr_model.sv ====
`timescale 1ns/1ns
module rlv_ldr_model (
   // clock
   input wire        i_sys_clk,
   // command from the block
   input wire        i_cmd_valid,
   input wire [4:0]  i_cmd_sa,
   input wire        i_cmd_tr,
   input wire [4:0]  i_cmd_wc,
   input wire [15:0] i_tx_data,
   // transaction set-up
   input wire [15:0] i_hw1,
   input wire [15:0] i_hw2,
   input wire [15:0] i_hw3,
   input wire [15:0] i_hw4,
   input wire        i_busy_on,
   input wire        i_bad_sum,
   // replies
   output reg        o_rx_valid,
   output reg [15:0] o_rx_data,
   output reg        o_tx_req,
   output reg        o_msg_done,
   output reg        o_msg_busy,
   output reg        o_busy_clr,
   output reg [7:0]  o_vfy_err
);
   integer    cq = 0;
   integer    sq = 0;
   integer    idx;
   reg        bpend;
   reg [15:0] sum;
   function [15:0] dw(input integer k);
      dw = 16'hc35a ^ k[15:0];
   endfunction
   always @(posedge i_sys_clk) begin
      if (i_cmd_valid)
         cq <= cq + 1;
   end
   task serve;
      integer    n;
      integer    i;
      reg [15:0] w;
      begin
         n = (i_cmd_wc == 5'h00) ? 32 : i_cmd_wc;
         if (i_cmd_sa == 5'h14) begin
            idx = 0;
            sum = 16'h0000;
            bpend = i_busy_on;
         end
         @(posedge i_sys_clk);
         // busy status, no data taken or sent
         if (i_cmd_sa == 5'h15 && bpend) begin
            bpend = 1'b0;
            o_msg_done <= 1'b1;
            o_msg_busy <= 1'b1;
            @(posedge i_sys_clk);
            o_msg_done <= 1'b0;
            o_msg_busy <= 1'b0;
            repeat (3) @(posedge i_sys_clk);
            o_busy_clr <= 1'b1;
            @(posedge i_sys_clk);
            o_busy_clr <= 1'b0;
         end else begin
            for (i = 0; i < n; i = i + 1) begin
               case (i_cmd_sa)
                  5'h14: w = (i == 0) ? i_hw1 : (i == 1) ? i_hw2 : (i == 2) ? i_hw3 : i_hw4;
                  5'h16: w = (i == 0) ? 16'h0000 : sum ^ {15'h0000, i_bad_sum};
                  default: w = i_cmd_tr ? dw(idx) : (i_hw2 + idx[15:0]) ^ 16'h3c00;
               endcase
               // running sum of all but the checksum word
               if (!(i_cmd_sa == 5'h16 && i == 1))
                  sum = sum + w;
               if (i_cmd_sa == 5'h15)
                  idx = idx + 1;
               if (i_cmd_tr) begin
                  o_rx_valid <= 1'b1;
                  o_rx_data <= w;
                  @(posedge i_sys_clk);
               end else begin
                  o_tx_req <= 1'b1;
                  @(posedge i_sys_clk);
                  o_tx_req <= 1'b0;
                  @(posedge i_sys_clk);
                  if (i_tx_data !== w)
                     o_vfy_err <= o_vfy_err + 8'h01;
               end
            end
            o_rx_valid <= 1'b0;
            o_rx_data <= ~o_rx_data;
            o_msg_done <= 1'b1;
            @(posedge i_sys_clk);
            o_msg_done <= 1'b0;
         end
      end
   endtask
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 16'h0000;
      o_tx_req = 1'b0;
      o_msg_done = 1'b0;
      o_msg_busy = 1'b0;
      o_busy_clr = 1'b0;
      o_vfy_err = 8'h00;
      forever begin
         @(posedge i_sys_clk);
         if (cq != sq) begin
            sq = sq + 1;
            serve;
         end
      end
   end
endmodule // rlv_ldr_model

// ==== verif/rlv_txn_sva.sv ====
`timescale 1ns/1ns
module rlv_chk (
   // clock and reset
   input wire       i_sys_clk,
   input wire       i_rstn,
   // register bus
   input wire       i_avs_read,
   input wire       i_avs_write,
   input wire       o_avs_waitrequest,
   // message engine
   input wire       o_cmd_valid,
   input wire [4:0] o_cmd_sa,
   input wire       o_cmd_tr,
   input wire [4:0] o_cmd_wc,
   input wire       i_msg_done,
   input wire       i_msg_busy,
   input wire       i_msg_err,
   input wire       i_busy_clr,
   // memory and handoff
   input wire       i_exec,
   input wire       o_wr_valid,
   input wire       o_jump_valid
);
   reg        inmsg_r;
   reg        bwait_r;
   reg        clr_r;
   reg        trl_r;
   reg        exec_r;
   reg [10:0] last_r;
   default clocking dc @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // track message in flight, busy retry and trailer completion
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         inmsg_r <= 1'b0;
         bwait_r <= 1'b0;
         clr_r   <= 1'b0;
         trl_r   <= 1'b0;
         exec_r  <= 1'b0;
         last_r  <= 11'h000;
      end else begin
         if (o_cmd_valid) begin
            inmsg_r <= 1'b1;
            bwait_r <= 1'b0;
            clr_r   <= 1'b0;
            trl_r   <= 1'b0;
            last_r  <= {o_cmd_sa, o_cmd_tr, o_cmd_wc};
         end else if (i_msg_done) begin
            inmsg_r <= 1'b0;
            bwait_r <= i_msg_busy;
            trl_r   <= !i_msg_busy && !i_msg_err && o_cmd_sa == 5'h16;
         end
         if (i_busy_clr)
            clr_r <= 1'b1;
         exec_r <= i_exec;
      end
   end
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_hdr;
      o_cmd_valid && o_cmd_sa == 5'h14;
   endsequence
   sequence s_trl;
      o_cmd_valid && o_cmd_sa == 5'h16;
   endsequence
   a_wait_answer: assert property (s_req |=> !o_avs_waitrequest)
      else $error("bus request not answered next cycle");
   a_wait_once: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
      else $error("command strobe longer than one cycle");
   a_one_msg: assert property (o_cmd_valid |-> !inmsg_r)
      else $error("command issued while a message is open");
   a_hdr_cmd: assert property (s_hdr |-> o_cmd_tr && o_cmd_wc == 5'h04)
      else $error("header command malformed");
   a_trl_cmd: assert property (s_trl |-> o_cmd_tr && o_cmd_wc == 5'h02)
      else $error("trailer command malformed");
   a_wr_in_load: assert property (o_wr_valid |-> o_cmd_sa == 5'h15 && o_cmd_tr)
      else $error("memory write outside a load message");
   a_busy_retry: assert property (o_cmd_valid && bwait_r |-> clr_r &&
      {o_cmd_sa, o_cmd_tr, o_cmd_wc} == last_r)
      else $error("busy retry early or with another command");
   a_jump_late: assert property (o_jump_valid |-> trl_r || exec_r)
      else $error("jump before trailer completed");
endmodule // rlv_chk
bind rlv_txn rlv_chk chk_u (.*);

// ==== verif/test_rlv_txn.sv ====
`timescale 1ns/1ns
`include "rlv_regs.vh"
module test_rlv_txn;
   reg         i_sys_clk = 1'b0;
   reg         i_rstn = 1'b0;
   reg  [3:0]  adr = 4'h0;
   reg         rd = 1'b0;
   reg         wr = 1'b0;
   reg  [31:0] wd = 32'h0;
   reg         act = 1'b0;
   reg         exe = 1'b0;
   reg         bsy = 1'b0;
   reg         bad = 1'b0;
   reg  [15:0] h1 = 16'h0, h2 = 16'h0, h3 = 16'h0, h4 = 16'h0;
   reg  [1:0]  tm = 2'h0;
   reg  [28:0] base = 29'h0;
   reg  [28:0] jexp = 29'h0;
   reg  [31:0] q;
   integer     wn = 0, jn = 0;
   integer     error_cnt = 0, check_count = 0;
   wire [31:0] rdata, wdat;
   wire [15:0] rxd, txd, mrd;
   wire [28:0] maddr, waddr, jaddr;
   wire [4:0]  sa, wc;
   wire [7:0]  verr;
   wire        wreq, cv, tr, rxv, txr, dn, bz, bc, wv, ww, jv;
   assign mrd = maddr[15:0] ^ 16'h3c00;
   always #20 i_sys_clk = ~i_sys_clk;
   rlv_txn dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_act_req(act), .o_cmd_valid(cv), .o_cmd_sa(sa),
      .o_cmd_tr(tr), .o_cmd_wc(wc), .i_rx_valid(rxv), .i_rx_data(rxd), .i_tx_req(txr),
      .o_tx_data(txd), .i_msg_done(dn), .i_msg_busy(bz), .i_msg_err(1'b0),
      .i_busy_clr(bc), .o_mem_addr(maddr), .i_mem_rdata(mrd), .o_wr_valid(wv),
      .o_wr_wide(ww), .o_wr_addr(waddr), .o_wr_data(wdat), .i_exec(exe),
      .o_jump_valid(jv), .o_jump_addr(jaddr));
   rlv_ldr_model prt_u (.i_sys_clk(i_sys_clk), .i_cmd_valid(cv), .i_cmd_sa(sa),
      .i_cmd_tr(tr), .i_cmd_wc(wc), .i_tx_data(txd), .i_hw1(h1), .i_hw2(h2), .i_hw3(h3),
      .i_hw4(h4), .i_busy_on(bsy), .i_bad_sum(bad), .o_rx_valid(rxv), .o_rx_data(rxd),
      .o_tx_req(txr), .o_msg_done(dn), .o_msg_busy(bz), .o_busy_clr(bc), .o_vfy_err(verr));
   function [15:0] dw(input integer k);
      dw = 16'hc35a ^ k[15:0];
   endfunction
   task cmp(input string nm, input [63:0] e, input [63:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wrap_up;
      begin
         if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task av(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge i_sys_clk);
         adr <= a;
         wd <= d;
         rd <= !w;
         wr <= w;
         @(posedge i_sys_clk);
         while (wreq !== 1'b0) begin
            @(posedge i_sys_clk);
         end
         q = rdata;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   // f = {verify, activity start, bad checksum, busy once}
   task run(input [15:0] a, b, c, d, input [3:0] f, input [31:0] m, s,
            input integer nw, nc);
      begin
         h1 <= a;
         h2 <= b;
         h3 <= c;
         h4 <= d;
         bsy <= f[0];
         bad <= f[1];
         tm = a[15:14];
         base = {d[15:3], b};
         wn = 0;
         jn = 0;
         av(1'b1, `RLV_A_CTRL, {30'h0, f[3], !f[2]});
         if (f[2]) begin
            act <= 1'b1;
            @(posedge i_sys_clk);
            act <= 1'b0;
         end
         q = 32'h0;
         while (q[1] !== 1'b1) begin
            av(1'b0, `RLV_A_STAT, 32'h0);
         end
         cmp("status", s, q & m);
         cmp("writes", nw, wn);
         av(1'b0, `RLV_A_CNT, 32'h0);
         if (nc >= 0)
            cmp("count", nc, q);
         av(1'b1, `RLV_A_STAT, 32'h7e);
      end
   endtask
   always @(posedge i_sys_clk) begin
      if (wv) begin
         case (tm)
            2'h3: cmp("wide", {1'b1, dw(2 * wn + 1), dw(2 * wn)}, {ww, wdat});
            2'h1: cmp("byte", {base + wn[28:0], 16'h0, dw(wn) & 16'h00ff}, {waddr, wdat});
            default: cmp("word", {base + wn[28:0], 16'h0, dw(wn)}, {waddr, wdat});
         endcase
         wn = wn + 1;
      end
      if (jv) begin
         jn = jn + 1;
         cmp("jump address", jexp, jaddr);
      end
   end
   initial begin
      #(40 * 40000);
      error_cnt = error_cnt + 1;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      // page field with bit 2 clear and handoff kept at more data
      run(16'h8028, 16'h0100, 0, 16'h0009, 4'h5, 32'h7f, 32'h02, 40, 40);
      run(16'h5002, 16'h0200, 0, 16'h0001, 4'h0, 32'h7f, 32'h02, 64, 64);
      run(16'hc004, 16'h0300, 0, 16'h0001, 4'h0, 32'h7f, 32'h02, 2, 4);
      run(16'h8021, 16'h0400, 0, 16'h0001, 4'h9, 32'h7f, 32'h02, 0, 33);
      cmp("verify words", 8'h00, verr);
      run(16'h8003, 16'h0500, 0, 16'h0001, 4'h2, 32'h06, 32'h06, 3, 3);
      run(16'h5801, 16'h0000, 0, 16'h0009, 4'h0, 32'h12, 32'h12, 0, -1);
      run(16'h8001, 16'h0000, 0, 16'h0003, 4'h0, 32'h12, 32'h12, 0, -1);
      run(16'h8000, 16'h0000, 0, 16'h0001, 4'h0, 32'h7f, 32'h02, 4096, 4096);
      jexp = {13'h0005, 16'h1234};
      run(16'h3fff, 16'hffff, 16'h1234, 16'h002a, 4'h0, 32'h7f, 32'h42, 0, -1);
      cmp("handoff jumps", 1, jn);
      jn = 0;
      exe <= 1'b1;
      @(posedge i_sys_clk);
      exe <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      cmp("execute jumps", 1, jn);
      av(1'b1, `RLV_A_HW3, 32'hffff);
      av(1'b0, `RLV_A_HW3, 32'h0);
      cmp("entry word", 32'h1234, q);
      av(1'b0, `RLV_A_STAT, 32'h0);
      cmp("status jump", 32'h40, q & 32'h7e);
      av(1'b0, 4'h8, 32'h0);
      cmp("unmapped", 32'h0, q);
      wrap_up;
   end
endmodule // test_rlv_txn

// ==== verilog/rlv_txn.v ====
`timescale 1ns/1ns
// Overview of operation
// - word1 bits 14-15 select transfer kind
// - no-transfer header ignores count and address
// - eight-bit kind keeps only bits 0-7
// - 32-bit kind: odd word low, even high
// - bits 12-13 header kind, words or messages
// - zero buffer count means 4096
// - word-count data in 32-word messages
// - paged 8/16-bit message count max 2048
// - word2 is low load address
// - entry address only from no-transfer header
// - word4 bits 3-15 are page bits
// - word4 bits 0-1 control handoff code
// - jump after trailer with verified data, or on execute input
// - activity request starts header command
// - load data by transmit subaddress 15h
// - busy load status: reissue same command
// - verify data sent on receive subaddress 15h
// - busy verify: resend identical words
// - trailer by transmit subaddress 16h
// - header by transmit subaddress 14h
// - sixteen-bit checksum over all words but the checksum word
`include "rlv_regs.vh"
module rlv_txn #(
   parameter AW = 29
) (
   // clock and reset
   input  wire          i_sys_clk,
   input  wire          i_rstn,
   // avalon-mm slave
   input  wire [3:0]    i_avs_address,
   input  wire          i_avs_read,
   input  wire          i_avs_write,
   input  wire [31:0]   i_avs_writedata,
   output reg  [31:0]   o_avs_readdata,
   output reg           o_avs_waitrequest,
   // 1553 message engine
   input  wire          i_act_req,
   output reg           o_cmd_valid,
   output reg  [4:0]    o_cmd_sa,
   output reg           o_cmd_tr,
   output reg  [4:0]    o_cmd_wc,
   input  wire          i_rx_valid,
   input  wire [15:0]   i_rx_data,
   input  wire          i_tx_req,
   output reg  [15:0]   o_tx_data,
   input  wire          i_msg_done,
   input  wire          i_msg_busy,
   input  wire          i_msg_err,
   input  wire          i_busy_clr,
   // unit memory
   output reg  [AW-1:0] o_mem_addr,
   input  wire [15:0]   i_mem_rdata,
   output reg           o_wr_valid,
   output reg           o_wr_wide,
   output reg  [AW-1:0] o_wr_addr,
   output reg  [31:0]   o_wr_data,
   // execution handoff
   input  wire          i_exec,
   output reg           o_jump_valid,
   output reg  [AW-1:0] o_jump_addr
);

   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_HCMD = 3'd1;
   localparam [2:0] S_HRX  = 3'd2;
   localparam [2:0] S_DCMD = 3'd3;
   localparam [2:0] S_DXF  = 3'd4;
   localparam [2:0] S_BUSY = 3'd5;
   localparam [2:0] S_TCMD = 3'd6;
   localparam [2:0] S_TRX  = 3'd7;

   function [12:0] btc_exp;
      input [15:0] w;
      begin
         if (w[`RLV_BTC_HI:0] == 12'h000) begin
            btc_exp = `RLV_BTC_MAX;
         end else begin
            btc_exp = {1'b0, w[`RLV_BTC_HI:0]};
         end
      end
   endfunction

   function [AW-1:0] page_addr;
      input [15:0] pg;
      input [15:0] lo;
      begin
         page_addr = {pg[15:`RLV_PG_LO], lo};
      end
   endfunction

   reg [2:0]    state_r;
   reg [2:0]    ret_r;
   reg          vfy_r;
   reg [15:0]   hw_r [0:3];
   reg [1:0]    hidx_r;
   reg [15:0]   sum_r;
   reg [15:0]   msum_r;
   reg [12:0]   msgs_r;
   reg [12:0]   wleft_r;
   reg [17:0]   cnt_r;
   reg [17:0]   mcnt_r;
   reg [17:0]   exp_r;
   reg [AW-1:0] maddr_r;
   reg          odd_r;
   reg [15:0]   lo_r;
   reg          tidx_r;
   reg [15:0]   csum_r;
   reg [AW-1:0] entry_r;
   reg [6:1]    stat_r;
   reg [4:0]    wc_r;

   wire [1:0]   tm  = hw_r[0][`RLV_TM_HI:`RLV_TM_LO];
   wire [1:0]   ht  = hw_r[0][`RLV_HT_HI:`RLV_HT_LO];
   wire [1:0]   tc  = hw_r[3][`RLV_TC_HI:0];
   wire [12:0]  btc = btc_exp(hw_r[0]);
   wire         pg_used = (hw_r[3][15:`RLV_PG_LO] != 13'h0000);
   wire [12:0]  wc_full = `RLV_MSG_M1 + 13'h0001;

   // header validity after the fourth word
   reg          hdr_bad;
   always @* begin
      hdr_bad = 1'b0;
      if (ht != `RLV_HT_WORDS && ht != `RLV_HT_MSGS) begin
         hdr_bad = 1'b1;
      end
      if (tc == `RLV_TC_BAD) begin
         hdr_bad = 1'b1;
      end
      if (ht == `RLV_HT_MSGS && tm != `RLV_TM_32 && pg_used && btc > `RLV_PG_MAX) begin
         hdr_bad = 1'b1;
      end
   end

   wire        bus_req = (i_avs_read | i_avs_write) & o_avs_waitrequest;
   wire        wr_ack  = i_avs_write & ~o_avs_waitrequest;
   wire        go      = (wr_ack && i_avs_address == `RLV_A_CTRL &&
                          i_avs_writedata[`RLV_C_GO]) | i_act_req;
   wire [6:1]  clr     = (wr_ack && i_avs_address == `RLV_A_STAT) ?
                         i_avs_writedata[6:1] : 6'h00;
   reg  [31:0] rdata;

   always @* begin
      if (i_avs_address == `RLV_A_CTRL) begin
         rdata = {30'h0, vfy_r, 1'b0};
      end else if (i_avs_address == `RLV_A_STAT) begin
         rdata = {25'h0, stat_r, state_r != S_IDLE};
      end else if (i_avs_address == `RLV_A_HW1) begin
         rdata = {16'h0, hw_r[0]};
      end else if (i_avs_address == `RLV_A_HW2) begin
         rdata = {16'h0, hw_r[1]};
      end else if (i_avs_address == `RLV_A_HW3) begin
         rdata = {16'h0, hw_r[2]};
      end else if (i_avs_address == `RLV_A_HW4) begin
         rdata = {16'h0, hw_r[3]};
      end else if (i_avs_address == `RLV_A_SUM) begin
         rdata = {16'h0, sum_r};
      end else if (i_avs_address == `RLV_A_CNT) begin
         rdata = {14'h0, cnt_r};
      end else begin
         rdata = 32'h0;
      end
   end

   // bus slave: one wait cycle, answer on the second
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0;
         vfy_r             <= 1'b0;
      end else begin
         o_avs_waitrequest <= ~bus_req;
         if (bus_req) begin
            o_avs_readdata <= rdata;
         end
         if (wr_ack && i_avs_address == `RLV_A_CTRL) begin
            vfy_r <= i_avs_writedata[`RLV_C_VFY];
         end
      end
   end

   // transaction sequencer
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r      <= S_IDLE;
         ret_r        <= S_IDLE;
         hw_r[0]      <= 16'h0;
         hw_r[1]      <= 16'h0;
         hw_r[2]      <= 16'h0;
         hw_r[3]      <= 16'h0;
         hidx_r       <= 2'h0;
         sum_r        <= 16'h0;
         msum_r       <= 16'h0;
         msgs_r       <= 13'h0;
         wleft_r      <= 13'h0;
         cnt_r        <= 18'h0;
         mcnt_r       <= 18'h0;
         exp_r        <= 18'h0;
         maddr_r      <= {AW{1'b0}};
         odd_r        <= 1'b1;
         lo_r         <= 16'h0;
         tidx_r       <= 1'b0;
         csum_r       <= 16'h0;
         entry_r      <= {AW{1'b0}};
         stat_r       <= 6'h00;
         wc_r         <= 5'h0;
         o_cmd_valid  <= 1'b0;
         o_cmd_sa     <= 5'h0;
         o_cmd_tr     <= 1'b0;
         o_cmd_wc     <= 5'h0;
         o_tx_data    <= 16'h0;
         o_mem_addr   <= {AW{1'b0}};
         o_wr_valid   <= 1'b0;
         o_wr_wide    <= 1'b0;
         o_wr_addr    <= {AW{1'b0}};
         o_wr_data    <= 32'h0;
         o_jump_valid <= 1'b0;
         o_jump_addr  <= {AW{1'b0}};
      end else begin
         o_cmd_valid  <= 1'b0;
         o_wr_valid   <= 1'b0;
         o_jump_valid <= 1'b0;
         // sticky status: later bit sets override this clear
         stat_r <= stat_r & ~clr;
         if (i_exec) begin
            o_jump_valid <= 1'b1;
            o_jump_addr  <= entry_r;
            stat_r[`RLV_S_JUMP] <= 1'b1;
         end
         case (state_r)
            S_IDLE: begin
               if (go) begin
                  sum_r   <= 16'h0;
                  cnt_r   <= 18'h0;
                  hidx_r  <= 2'h0;
                  tidx_r  <= 1'b0;
                  odd_r   <= 1'b1;
                  state_r <= S_HCMD;
               end
            end
            S_HCMD: begin
               o_cmd_valid <= 1'b1;
               o_cmd_sa    <= `RLV_SA_HDR;
               o_cmd_tr    <= 1'b1;
               o_cmd_wc    <= `RLV_WC_HDR;
               msum_r      <= sum_r;
               ret_r       <= S_HCMD;
               state_r     <= S_HRX;
            end
            S_HRX: begin
               if (i_rx_valid) begin
                  hw_r[hidx_r] <= i_rx_data;
                  hidx_r       <= hidx_r + 2'h1;
                  sum_r        <= sum_r + i_rx_data;
               end
               if (i_msg_done) begin
                  if (i_msg_err) begin
                     stat_r[`RLV_S_EBUS] <= 1'b1;
                     state_r <= S_IDLE;
                  end else if (i_msg_busy) begin
                     sum_r   <= msum_r;
                     hidx_r  <= 2'h0;
                     state_r <= S_BUSY;
                  end else if (tm == `RLV_TM_NONE) begin
                     entry_r <= page_addr(hw_r[3], hw_r[2]);
                     exp_r   <= 18'h0;
                     state_r <= S_TCMD;
                  end else if (hdr_bad) begin
                     stat_r[`RLV_S_EHDR] <= 1'b1;
                     exp_r   <= 18'h0;
                     state_r <= S_TCMD;
                  end else begin
                     o_mem_addr <= page_addr(hw_r[3], hw_r[1]);
                     o_wr_addr  <= page_addr(hw_r[3], hw_r[1]);
                     wleft_r    <= btc;
                     if (ht == `RLV_HT_WORDS) begin
                        msgs_r <= (btc + `RLV_MSG_M1) >> `RLV_MSG_SH;
                        exp_r  <= {5'h00, btc};
                     end else begin
                        msgs_r <= btc;
                        exp_r  <= {btc, 5'h00};
                     end
                     state_r <= S_DCMD;
                  end
               end
            end
            S_DCMD: begin
               o_cmd_valid <= 1'b1;
               o_cmd_sa    <= `RLV_SA_DATA;
               o_cmd_tr    <= ~vfy_r;
               if (ht == `RLV_HT_WORDS && wleft_r < wc_full) begin
                  o_cmd_wc <= wleft_r[4:0];
                  wc_r     <= wleft_r[4:0];
               end else begin
                  o_cmd_wc <= `RLV_WC_FULL;
                  wc_r     <= `RLV_WC_FULL;
               end
               msum_r  <= sum_r;
               mcnt_r  <= cnt_r;
               maddr_r <= o_mem_addr;
               ret_r   <= S_DCMD;
               state_r <= S_DXF;
            end
            S_DXF: begin
               if (!vfy_r && i_rx_valid) begin
                  sum_r <= sum_r + i_rx_data;
                  cnt_r <= cnt_r + 18'h1;
                  // odd word low, even word high
                  if (tm == `RLV_TM_32) begin
                     odd_r <= ~odd_r;
                     lo_r  <= i_rx_data;
                     if (!odd_r) begin
                        o_wr_valid <= 1'b1;
                        o_wr_wide  <= 1'b1;
                        o_wr_data  <= {i_rx_data, lo_r};
                     end
                  end else begin
                     o_wr_valid <= 1'b1;
                     o_wr_wide  <= 1'b0;
                     if (tm == `RLV_TM_8) begin
                        o_wr_data <= {16'h0, i_rx_data & `RLV_LO8};
                     end else begin
                        o_wr_data <= {16'h0, i_rx_data};
                     end
                  end
                  if (o_wr_valid) begin
                     o_wr_addr <= o_wr_addr + {{(AW-1){1'b0}}, 1'b1};
                  end
               end else if (o_wr_valid) begin
                  o_wr_addr <= o_wr_addr + {{(AW-1){1'b0}}, 1'b1};
               end
               if (vfy_r && i_tx_req) begin
                  o_tx_data  <= i_mem_rdata;
                  sum_r      <= sum_r + i_mem_rdata;
                  cnt_r      <= cnt_r + 18'h1;
                  o_mem_addr <= o_mem_addr + {{(AW-1){1'b0}}, 1'b1};
               end
               if (i_msg_done) begin
                  if (i_msg_err) begin
                     stat_r[`RLV_S_EBUS] <= 1'b1;
                     state_r <= S_IDLE;
                  end else if (i_msg_busy) begin
                     sum_r      <= msum_r;
                     cnt_r      <= mcnt_r;
                     o_mem_addr <= maddr_r;
                     state_r    <= S_BUSY;
                  end else begin
                     msgs_r  <= msgs_r - 13'h1;
                     // a word count of zero stands for a full message
                     if (wc_r == `RLV_WC_FULL) begin
                        wleft_r <= wleft_r - wc_full;
                     end else begin
                        wleft_r <= wleft_r - {8'h00, wc_r};
                     end
                     if (msgs_r == 13'h1) begin
                        state_r <= S_TCMD;
                     end else begin
                        state_r <= S_DCMD;
                     end
                  end
               end
            end
            S_BUSY: begin
               if (i_busy_clr) begin
                  state_r <= ret_r;
               end
            end
            S_TCMD: begin
               o_cmd_valid <= 1'b1;
               o_cmd_sa    <= `RLV_SA_TRL;
               o_cmd_tr    <= 1'b1;
               o_cmd_wc    <= `RLV_WC_TRL;
               msum_r      <= sum_r;
               tidx_r      <= 1'b0;
               ret_r       <= S_TCMD;
               state_r     <= S_TRX;
            end
            default: begin
               if (i_rx_valid) begin
                  tidx_r <= 1'b1;
                  if (!tidx_r) begin
                     sum_r <= sum_r + i_rx_data;
                  end else begin
                     csum_r <= i_rx_data;
                  end
               end
               if (i_msg_done) begin
                  state_r <= S_IDLE;
                  if (i_msg_err) begin
                     stat_r[`RLV_S_EBUS] <= 1'b1;
                  end else if (i_msg_busy) begin
                     sum_r   <= msum_r;
                     state_r <= S_BUSY;
                  end else begin
                     stat_r[`RLV_S_DONE] <= 1'b1;
                     if (sum_r != csum_r) begin
                        stat_r[`RLV_S_ECSUM] <= 1'b1;
                     end
                     if (cnt_r != exp_r) begin
                        stat_r[`RLV_S_ECNT] <= 1'b1;
                     end
                     if (tc == `RLV_TC_JUMP && sum_r == csum_r && cnt_r == exp_r &&
                         !stat_r[`RLV_S_EHDR]) begin
                        o_jump_valid <= 1'b1;
                        o_jump_addr  <= entry_r;
                        stat_r[`RLV_S_JUMP] <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

endmodule // rlv_txn
